// ===== core/serial_port.v
// byte-wide synchronous serial port, master or slave, full duplex
// assumes software-side controls are synchronous pulses and levels on CLK;
// serial pins are resolved by the surrounding pad logic from the enables
`timescale 1ns/1ps
`include "serial_port_regs.vh"

// Contract
// [RL1] master drives clock, swaps eight bits
// [RL2] slave shifts on external clock edges
// [RL3] bit order control picks shift direction
// [RL4] order 0 msb first, 1 lsb first
// [RL5] idle-level control sets output after word
// [RL6] idle control 0 high, 1 low
// [RL7] delay field sets output hold time
// [RL8] codes give 8, 16, 24, 32 cycles
// [RL9] bit rate limited to 8 MHz
// [RL10] go loads pending word and starts
// [RL11] data write loads buffer and shifter
// [RL12] go reads 1 until word completes
// [RL13] writes ignored while shifting
// [RL14] received bits replace outgoing word
// [RL15] buffer full set at word end
// [RL16] word end copies data, sets flags
// [RL17] reading buffer clears full flag
// [RL18] software reads before next word ends
// [RL19] rate field picks internal or external
// [RL20] codes 0-5 divide, 6-7 slave
// [RL21] edge control picks shift/sample edges
// [RL22] slave ignores edge and divider settings
// [RL23] data input ignored when not selected
// [RL24] both ends share rate and edge
// [RL25] master holds select low whole word; the core has no select output and drives no select pin
// [RL26] deselected slave ignores, releases output
// [RL27] select input optional, slave only
// [RL28] slave pins synchronised, edges detected
module serial_port (
    input  wire       CLK,
    input  wire       SRST,
    input  wire       PORT_ENABLE,
    input  wire       BIT_ORDER,
    input  wire       OUT_IDLE_LEVEL,
    input  wire [1:0] OUT_DELAY,
    input  wire [2:0] RATE_SELECT,
    input  wire       CLOCK_EDGE_SELECT,
    input  wire       SHIFT_GO_SET,
    input  wire       TX_WRITE,
    input  wire [7:0] TX_DATA,
    input  wire       RX_READ,
    input  wire       IRQ_FLAG_CLEAR,
    input  wire       SCK_I,
    input  wire       SI,
    input  wire       SS_N,
    output wire       SHIFT_GO,
    output wire       READ_BUFFER_FULL,
    output wire       RECEIVE_DONE_IRQ_FLAG,
    output wire [7:0] RX_DATA,
    output wire       SCK_O,
    output wire       SCK_OE,
    output wire       SO_O,
    output wire       SO_OE
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_HOLD  = 2'h2;

    // fastest half period that keeps the bit rate legal
    localparam integer MIN_HALF_I =
        (`SP_CLK_HZ + 2 * `SP_MAX_BIT_HZ - 1) / (2 * `SP_MAX_BIT_HZ);
    localparam [5:0] MIN_HALF = MIN_HALF_I[5:0];

    // half period of the master clock in core cycles
    function [5:0] half_cycles;
        input [2:0] rate;
        reg   [5:0] base;
        begin
            base = 6'h01 << rate;
            if (base < MIN_HALF) begin // RL9
                half_cycles = MIN_HALF;
            end else begin
                half_cycles = base; // RL20
            end
        end
    endfunction

    // outgoing bit at the active end of the shifter
    function out_bit;
        input [7:0] sr;
        input       order;
        begin
            if (order == `SP_ORDER_MSB) begin // RL4
                out_bit = sr[7];
            end else begin
                out_bit = sr[0];
            end
        end
    endfunction

    // incoming bit enters at the far end of the same shifter
    function [7:0] shift_in;
        input [7:0] sr;
        input       din;
        input       order;
        begin
            if (order == `SP_ORDER_MSB) begin // RL4
                shift_in = {sr[6:0], din};
            end else begin
                shift_in = {din, sr[7:1]};
            end
        end
    endfunction

    // hold time after the last bit, in core cycles minus one
    function [5:0] hold_cycles;
        input [1:0] code;
        reg   [5:0] steps;
        begin
            steps = {4'h0, code} + 6'h01;
            hold_cycles = steps * `SP_OUT_DELAY_UNIT - 6'h01; // RL8
        end
    endfunction

    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg        shift_go_q;
    reg        rbf_q;
    reg        irq_q;
    reg  [7:0] rx_q;
    reg  [7:0] wb_q;
    reg  [7:0] sr_q;
    reg  [7:0] sr_d;
    reg  [2:0] bit_cnt_q;
    reg  [5:0] div_cnt_q;
    reg  [5:0] hold_cnt_q;
    reg        sck_q;
    reg        so_q;

    wire       sck_lvl;
    wire       sck_rise;
    wire       sck_fall;
    wire       ss_lvl;
    wire       si_lvl;

    // slave pins come in through synchronisers before any edge use
    pin_sync #(.RESET_VAL(`SP_SCK_IN_IDLE)) u_sck_sync ( // RL28
        .CLK   (CLK),
        .SRST  (SRST),
        .D     (SCK_I),
        .LEVEL (sck_lvl),
        .RISE  (sck_rise),
        .FALL  (sck_fall)
    );

    pin_sync #(.RESET_VAL(`SP_SS_RESET)) u_ss_sync ( // RL28
        .CLK   (CLK),
        .SRST  (SRST),
        .D     (SS_N),
        .LEVEL (ss_lvl),
        .RISE  (),
        .FALL  ()
    );

    // slave data input delayed alike so it lines up with its clock edges;
    // master takes the raw pin, two stages would equal the fastest half period
    pin_sync #(.RESET_VAL(1'h0)) u_si_sync (
        .CLK   (CLK),
        .SRST  (SRST),
        .D     (SI),
        .LEVEL (si_lvl),
        .RISE  (),
        .FALL  ()
    );

    wire is_slave  = (RATE_SELECT == `SP_RATE_SLAVE_SS) |
                     (RATE_SELECT == `SP_RATE_SLAVE_FREE); // RL19
    wire is_master = ~is_slave;
    // select pin only counts with code 6; code 7 is always selected
    wire selected  = is_master | (RATE_SELECT != `SP_RATE_SLAVE_SS) |
                     ~ss_lvl; // RL27
    wire sck_idle  = CLOCK_EDGE_SELECT; // RL21
    wire shifting  = (state_q == ST_SHIFT);
    wire div_tick  = (div_cnt_q == half_cycles(RATE_SELECT) - 6'h01);

    // master: leading edge leaves idle level, trailing returns to it;
    // slave: fixed falling-out, rising-in, edge control not used
    wire lead_ev  = shifting & (is_master ?
                    (div_tick & (sck_q == sck_idle)) :
                    (selected & sck_fall)); // RL22
    wire trail_ev = shifting & (is_master ?
                    (div_tick & (sck_q != sck_idle)) :
                    (selected & sck_rise)); // RL2
    wire word_end = trail_ev & (bit_cnt_q == `SP_LAST_BIT); // RL1
    wire wr_ok    = TX_WRITE & ~shifting; // RL13
    wire go_ok    = SHIFT_GO_SET & PORT_ENABLE & ~shifting;
    wire [7:0] go_word = wr_ok ? TX_DATA : wb_q;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (go_ok) begin
                    state_d = ST_SHIFT; // RL10
                end
            end
            ST_SHIFT: begin
                if (!PORT_ENABLE) begin
                    state_d = ST_IDLE;
                end else if (word_end) begin
                    state_d = ST_HOLD; // RL7
                end
            end
            ST_HOLD: begin
                if (go_ok) begin
                    state_d = ST_SHIFT;
                end else if (hold_cnt_q == 6'h00) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @* begin
        sr_d = sr_q;
        if (go_ok) begin
            sr_d = go_word; // RL10
        end else if (wr_ok) begin
            sr_d = TX_DATA; // RL11
        end else if (trail_ev) begin
            sr_d = shift_in(sr_q, is_master ? SI : si_lvl, BIT_ORDER); // RL14
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            state_q <= ST_IDLE;
            sr_q    <= 8'h00;
            wb_q    <= 8'h00;
        end else begin
            state_q <= state_d;
            sr_q    <= sr_d;
            if (wr_ok) begin
                wb_q <= TX_DATA; // RL11
            end
        end
    end

    // go flag: set by software, cleared by hardware at word end
    always @(posedge CLK) begin
        if (SRST) begin
            shift_go_q <= 1'h0;
        end else if (go_ok) begin
            shift_go_q <= 1'h1; // RL12
        end else if (word_end | ~PORT_ENABLE) begin
            shift_go_q <= 1'h0; // RL12
        end
    end

    // completion flags: a set in the clear cycle wins
    always @(posedge CLK) begin
        if (SRST) begin
            rbf_q <= 1'h0;
            irq_q <= 1'h0;
            rx_q  <= 8'h00;
        end else begin
            if (word_end) begin
                rx_q  <= sr_d; // RL16
                rbf_q <= 1'h1; // RL15
                irq_q <= 1'h1; // RL16
            end else begin
                if (RX_READ) begin
                    rbf_q <= 1'h0; // RL17
                end
                if (IRQ_FLAG_CLEAR) begin
                    irq_q <= 1'h0;
                end
            end
        end
    end

    // bit counter; a deselected slave restarts its word
    always @(posedge CLK) begin
        if (SRST) begin
            bit_cnt_q <= `SP_FIRST_BIT;
        end else if (go_ok | (is_slave & ~selected)) begin
            bit_cnt_q <= `SP_FIRST_BIT; // RL26
        end else if (trail_ev) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // master clock divider and clock pin level
    always @(posedge CLK) begin
        if (SRST) begin
            div_cnt_q <= 6'h00;
            sck_q     <= `SP_SCK_RESET;
        end else if (!shifting | is_slave | go_ok) begin
            div_cnt_q <= 6'h00;
            sck_q     <= sck_idle;
        end else if (div_tick) begin
            div_cnt_q <= 6'h00;
            sck_q     <= ~sck_q; // RL1
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
        end
    end

    // data out: new bit on each leading edge, held after the word,
    // then the chosen idle level once the hold time has run
    always @(posedge CLK) begin
        if (SRST) begin
            so_q       <= `SP_SO_RESET;
            hold_cnt_q <= 6'h00;
        end else begin
            if (lead_ev) begin
                so_q <= out_bit(sr_q, BIT_ORDER); // RL3
            end else if (state_q == ST_IDLE && !go_ok) begin
                so_q <= ~OUT_IDLE_LEVEL; // RL5 RL6
            end
            if (word_end) begin
                hold_cnt_q <= hold_cycles(OUT_DELAY); // RL7
            end else if (state_q == ST_HOLD && hold_cnt_q != 6'h00) begin
                hold_cnt_q <= hold_cnt_q - 6'h01;
            end
        end
    end

    assign SHIFT_GO              = shift_go_q;
    assign READ_BUFFER_FULL      = rbf_q;
    assign RECEIVE_DONE_IRQ_FLAG = irq_q;
    assign RX_DATA               = rx_q;
    assign SCK_O                 = sck_q;
    assign SCK_OE                = PORT_ENABLE & is_master; // RL1
    // a deselected slave lets go of the data line
    assign SO_O                  = so_q;
    assign SO_OE                 = PORT_ENABLE & selected; // RL26 RL23
endmodule

// ===== include/serial_port_regs.vh
// constants for the synchronous serial port core
// assumes a single core clock at the rate named below
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// core clock and the fastest allowed bit rate
`define SP_CLK_HZ          20000000
`define SP_MAX_BIT_HZ      8000000

// word length and bit counter
`define SP_WORD_BITS       8
`define SP_LAST_BIT        3'h7
`define SP_FIRST_BIT       3'h0

// rate select codes
`define SP_RATE_SLAVE_SS   3'h6
`define SP_RATE_SLAVE_FREE 3'h7

// bit order codes
`define SP_ORDER_MSB       1'h0

// output hold delay: unit of core cycles per code step
`define SP_OUT_DELAY_UNIT  6'h08

// pin reset levels
`define SP_SCK_RESET       1'h0
`define SP_SCK_IN_IDLE     1'h1
`define SP_SS_RESET        1'h1
`define SP_SO_RESET        1'h1

`endif

// ===== core/pin_sync.v
// two-stage synchroniser with edge detect for serial pins
// assumes inputs arrive asynchronously to CLK
`timescale 1ns/1ps
module pin_sync #(
    parameter RESET_VAL = 1'h0
) (
    input  wire CLK,
    input  wire SRST,
    input  wire D,
    output wire LEVEL,
    output wire RISE,
    output wire FALL
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // s1_q feeds s2_q only; edges come from the later stages
    always @(posedge CLK) begin
        if (SRST) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= D;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign LEVEL = s2_q;
    assign RISE  = s2_q & ~s3_q;
    assign FALL  = ~s2_q & s3_q;
endmodule

// ===== dv/serial_port_asserts.sv
// pin-level assertions for the serial port core
// assumes one clock domain, bound to every serial_port
`timescale 1ns/1ps
module serial_port_asserts (
    input wire       CLK,
    input wire       SRST,
    input wire       PORT_ENABLE,
    input wire       OUT_IDLE_LEVEL,
    input wire [2:0] RATE_SELECT,
    input wire       CLOCK_EDGE_SELECT,
    input wire       SHIFT_GO_SET,
    input wire       RX_READ,
    input wire       SS_N,
    input wire       SHIFT_GO,
    input wire       READ_BUFFER_FULL,
    input wire       RECEIVE_DONE_IRQ_FLAG,
    input wire       SCK_O,
    input wire       SCK_OE,
    input wire       SO_O,
    input wire       SO_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    a_go_starts: assert property (SHIFT_GO_SET && PORT_ENABLE && !SHIFT_GO |=> SHIFT_GO)
        else $error("shift_go did not rise");
    a_word_flags: assert property ($fell(SHIFT_GO) && $past(PORT_ENABLE && !SRST)
        |-> READ_BUFFER_FULL && RECEIVE_DONE_IRQ_FLAG) else $error("flags not set");
    a_read_clears: assert property (RX_READ |=> !READ_BUFFER_FULL || $fell(SHIFT_GO))
        else $error("full flag not cleared");
    a_clock_dir: assert property (SCK_OE == (PORT_ENABLE && RATE_SELECT < 3'h6))
        else $error("clock enable wrong");
    a_deselect_release: assert property ((RATE_SELECT == 3'h6 && SS_N)[*4] |-> !SO_OE)
        else $error("deselected slave drives");
    a_idle_level: assert property ($fell(SHIFT_GO) && $past(PORT_ENABLE && !SRST)
        |-> ##34 (SO_O != OUT_IDLE_LEVEL || SHIFT_GO)) else $error("idle level wrong");
    a_hold_bit: assert property ($fell(SHIFT_GO) && $past(!SRST) |-> $stable(SO_O)[*7])
        else $error("last bit not held");
    a_clock_idle: assert property ((!SHIFT_GO && SCK_OE && $stable(CLOCK_EDGE_SELECT))[*4]
        |-> SCK_O == CLOCK_EDGE_SELECT) else $error("clock idle level wrong");
    c_master: cover property ($fell(SHIFT_GO) && RATE_SELECT < 3'h6);
    c_slave: cover property ($fell(SHIFT_GO) && RATE_SELECT == 3'h6);
    c_read: cover property (RX_READ && READ_BUFFER_FULL);
endmodule
bind serial_port serial_port_asserts serial_port_asserts_inst (.CLK, .SRST, .PORT_ENABLE,
    .OUT_IDLE_LEVEL, .RATE_SELECT, .CLOCK_EDGE_SELECT, .SHIFT_GO_SET, .RX_READ, .SS_N,
    .SHIFT_GO, .READ_BUFFER_FULL, .RECEIVE_DONE_IRQ_FLAG, .SCK_O, .SCK_OE, .SO_O, .SO_OE);

// ===== dv/serial_peer_model.sv
// far-side peer: follows the port clock, or leads it with a select
// assumes one eight-bit frame per go pulse, tx given in wire order
`timescale 1ns/1ps
module serial_peer_model (
    input  wire       clk,
    input  wire       lead,
    input  wire       go,
    input  wire       clock_edge_select,
    input  wire       sck_in,
    input  wire       so,
    input  wire [7:0] tx,
    output reg        sck_m,
    output reg        ss_n,
    output reg        si,
    output reg  [7:0] seq
);
    reg  [7:0] cnt = 8'h00;
    reg  [3:0] idx = 4'h0;
    reg  [3:0] n   = 4'h0;
    wire [4:0] ph  = cnt[7:3];
    wire       sck = lead ? sck_m : sck_in;
    wire       pol = lead | clock_edge_select;
    initial begin
        sck_m = 1'h1;
        ss_n = 1'h1;
        si = 1'h0;
        seq = 8'h00;
    end
    always @(posedge clk) begin
        if (go) begin
            idx <= 4'h0;
            n <= 4'h0;
        end else if (n == 4'h8 || idx == 4'h0)
            si <= !si; // released line never keeps its level
        cnt <= (go && lead) ? 8'h01 : ((cnt == 8'ha0 || cnt == 8'h00) ? 8'h00 : cnt + 8'h01);
        ss_n <= cnt == 8'h00 && !(go && lead);
        sck_m <= !(ph >= 5'h2 && ph <= 5'h11 && !ph[0]); // slow, stops between frames
    end
    always @(sck) begin
        if (sck !== pol) begin
            si <= tx[3'h7 - idx[2:0]];
            idx <= idx + 4'h1;
        end else begin
            seq <= {seq[6:0], so};
            n <= n + 4'h1;
        end
    end
endmodule

// ===== dv/test_serial_port.sv
// random words through the serial port in every rate mode
// assumes serial_port and the peer model are compiled first
`timescale 1ns/1ps
module test_serial_port;
    reg         clk = 1'h0;
    reg         srst = 1'h1;
    reg         order = 1'h0;
    reg         idle = 1'h0;
    reg  [1:0]  dly = 2'h0;
    reg  [2:0]  rate = 3'h2;
    reg         clock_edge_select = 1'h0;
    reg         go = 1'h0;
    reg         wr = 1'h0;
    reg  [7:0]  wdat = 8'h00;
    reg         rd = 1'h0;
    reg         iclr = 1'h0;
    reg         pgo = 1'h0;
    reg  [7:0]  pb = 8'h00;
    reg  [7:0]  sent = 8'h00;
    reg  [7:0]  ew;
    reg  [31:0] seed = 32'h39f0;
    integer     fails = 0;
    integer     checks_done = 0;
    integer     i;
    integer     k;
    wire        sgo, read_buffer_full, irq, scko, soo, psck, pssn, psi;
    wire [7:0]  rxd, pseq;
    always #25 clk = !clk;
    serial_port serial_port_inst (.CLK(clk), .SRST(srst), .PORT_ENABLE(1'h1),
        .BIT_ORDER(order), .OUT_IDLE_LEVEL(idle), .OUT_DELAY(dly), .RATE_SELECT(rate),
        .CLOCK_EDGE_SELECT(clock_edge_select), .SHIFT_GO_SET(go), .TX_WRITE(wr), .TX_DATA(wdat),
        .RX_READ(rd), .IRQ_FLAG_CLEAR(iclr), .SCK_I(psck), .SI(psi), .SS_N(pssn),
        .SHIFT_GO(sgo), .READ_BUFFER_FULL(read_buffer_full), .RECEIVE_DONE_IRQ_FLAG(irq), .RX_DATA(rxd),
        .SCK_O(scko), .SCK_OE(), .SO_O(soo), .SO_OE());
    serial_peer_model serial_peer_model_inst (.clk(clk), .lead(rate[2] & rate[1]), .go(pgo),
        .clock_edge_select(clock_edge_select), .sck_in(scko), .so(soo), .tx(wire_bits(pb, order)), .sck_m(psck),
        .ss_n(pssn), .si(psi), .seq(pseq));
    function [7:0] wire_bits(input [7:0] v, input o);
        integer j;
        for (j = 0; j < 8; j = j + 1)
            wire_bits[7 - j] = o ? v[j] : v[7 - j];
    endfunction
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task tally_and_finish;
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tick;
        @(posedge clk);
        #5;
    endtask
    task check(input [8*9-1:0] name, input [7:0] exp, input [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, got);
        end
    endtask
    initial begin
        tick;
        tick;
        srst = 1'h0;
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            rate = (i < 8) ? i[2:0] : seed[2:0];
            {clock_edge_select, dly, idle, order} = seed[7:3];
            pb = seed[15:8];
            tick;
            tick;
            pgo = 1'h1;
            if (!seed[16] || i == 0) begin
                wr = 1'h1;
                wdat = seed[31:24];
                sent = seed[31:24];
            end
            go = 1'h1;
            tick;
            {pgo, wr, go} = 3'h0;
            check("shift_go", 8'h01, {7'h0, sgo});
            wr = 1'h1;
            wdat = ~sent;
            tick;
            wr = 1'h0;
            for (k = 0; sgo === 1'h1 && k < 2000; k = k + 1)
                tick;
            if (k == 2000) begin
                fails = fails + 1;
                tally_and_finish;
            end
            ew = wire_bits(sent, order);
            check("rx_data", pb, rxd);
            check("full", 8'h01, {7'h0, read_buffer_full});
            check("irq", 8'h01, {7'h0, irq});
            check("peer_seq", ew, pseq);
            for (k = 0; soo !== !idle && k < 60; k = k + 1)
                tick;
            check("so_idle", {7'h0, !idle}, {7'h0, soo});
            if (ew[0] === idle)
                check("so_hold", 8'h01, {7'h0, k >= 8 * dly + 7 && k <= 8 * dly + 10});
            repeat (40) tick;
            rd = 1'h1;
            iclr = seed[17];
            tick;
            {rd, iclr} = 2'h0;
            check("full", 8'h00, {7'h0, read_buffer_full});
            check("irq", {7'h0, !seed[17]}, {7'h0, irq});
        end
        tally_and_finish;
    end
endmodule
